// ==== verilog/t1e1_line_map.svh ====
// register offsets, field positions, reset values and timing counts
// assumes it is included by bare name wherever these are needed
`ifndef T1E1_LINE_MAP_SVH
`define T1E1_LINE_MAP_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_INT_STAT 8'h08
`define REG_INT_MASK 8'h0C

// ----------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------
`define CTRL_EDGE_BIT 0
`define CTRL_RLOOP_BIT 1
`define CTRL_W 2
`define ST_LOS_BIT 0
`define ST_TX_IDLE_BIT 1
`define ST_HOST_BIT 2
`define ST_LOOP_BIT 3
`define ST_W 4
`define INT_LOS_SET_BIT 0
`define INT_LOS_CLR_BIT 1
`define INT_TX_IDLE_BIT 2
`define INT_W 3
`define PER_W 8
`define IDLE_W 9
`define PIN_W 8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CTRL_RESET 2'h0
`define INT_RESET 3'h0
`define PERIOD_INIT 8'h82
`define PERIOD_MAX 8'hFF

// ----------------------------------------------------------------
// timing: clock period and transmit clock stall time in ns
// ----------------------------------------------------------------
`define REF_PERIOD_NS 5
`define TX_IDLE_TIME_NS 1300
`define TX_IDLE_CYCLES ((`TX_IDLE_TIME_NS + `REF_PERIOD_NS - 1) / `REF_PERIOD_NS)
`define LOS_SPACE_RUN 8'hAF

`endif

// ==== verilog/t1e1_line_pkg.sv ====
// types shared by the line interface design
// assumes nothing beyond a SystemVerilog compiler
package t1e1_line_pkg;
  // ----------------------------------------------------------------
  // transmit driver states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TX_OFF = 2'h0,   // drivers released, clock grounded
    TX_SEND = 2'h1,  // framer rails drive the line
    TX_LOOP = 2'h2   // recovered data looped to the line
  } tx_state_t;

  // source of the recovered clock
  typedef enum logic {
    SRC_LINE = 1'h0,   // timed from received marks
    SRC_MASTER = 1'h1  // taken from the master clock
  } rclk_src_t;
endpackage : t1e1_line_pkg

// ==== verilog/pin_sync.sv ====
// two flip-flop synchroniser for a group of pins
// assumes every bit is asynchronous to clk and independent of the others
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 8  // number of pins
) (
  input wire logic clk,        // sampling clock
  input wire logic rst_n,      // async reset, active low
  input wire logic [W-1:0] d,  // raw pin levels
  output logic [W-1:0] q       // synchronised levels
);
  // ----------------------------------------------------------------
  // one two-stage chain per pin
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_r;  // first stage, read only by the second
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_r <= 1'b0;
          q[i] <= 1'b0;
        end else begin
          meta_r <= d[i];
          q[i] <= meta_r;
        end
      end
    end
  endgenerate
endmodule : pin_sync

// ==== verilog/t1e1_line_if.sv ====
// framer-side digital interface of a T1/E1 line transceiver
// assumes line pulses arrive as digital levels on LINE_RX_A/B and that
// all pins except the register port are asynchronous to REF_CLK
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
`include "t1e1_line_map.svh"

// Contract
// - transmit rails captured at transmit clock fall
// - grounded transmit clock releases drivers unless looping
// - internal timing derived from master clock
// - recovered clock follows master clock during loss
// - recovered clock follows received signal when present
// - each rail request yields matching line pulse; with both rails requested the code sends only the positive pulse
// - mode high: control through host registers
// - mode low: registers disabled, pins control
// - received pulses raise matching receive rail
// - receive rails held a full bit
// - hardware mode: rails valid at clock rise
// - host mode: edge select picks valid edge
// - signal lost after 175 spaces, mark clears
module t1e1_line_if (
  input wire logic REF_CLK,            // 200 MHz system clock
  input wire logic NRST,               // async reset, active low
  input wire logic MCLK,               // master reference clock pin
  input wire logic MODE,               // high host mode, low hardware mode
  input wire logic TX_LINE_CLOCK,      // framer transmit clock
  input wire logic TX_POS_RAIL,        // positive pulse request
  input wire logic TX_NEG_RAIL,        // negative pulse request
  input wire logic REMOTE_LOOP_PIN,    // loopback strap in hardware mode
  input wire logic LINE_RX_A,          // received positive pulse
  input wire logic LINE_RX_B,          // received negative pulse
  output logic LINE_TX_A,              // positive line pulse
  output logic LINE_TX_A_OE_N,         // low while driving
  output logic LINE_TX_B,              // negative line pulse
  output logic LINE_TX_B_OE_N,         // low while driving
  output logic RX_POS_RAIL,            // nrz positive data
  output logic RX_NEG_RAIL,            // nrz negative data
  output logic RX_CLOCK,               // recovered clock
  output logic SIGNAL_LOST_FLAG,       // loss of signal
  input wire logic [7:0] REG_ADDR,     // register byte address
  input wire logic [31:0] REG_WDATA,   // write data
  input wire logic REG_WR,             // write strobe
  input wire logic REG_RD,             // read strobe
  output logic [31:0] REG_RDATA,       // read data, cycle after strobe
  output logic IRQ                     // level interrupt
);
  // ----------------------------------------------------------------
  // pin synchronisation and edge detection
  // ----------------------------------------------------------------
  logic [`PIN_W-1:0] pins_s;  // synchronised pins
  logic mclk_s, mode_s, tx_line_clock_s, pos_s, neg_s, rloop_s, rxa_s, rxb_s;
  logic mclk_d, tx_line_clock_d, rxa_d, rxb_d;  // previous synced levels

  pin_sync #(.W(`PIN_W)) u_sync (
    .clk(REF_CLK),
    .rst_n(NRST),
    .d({MCLK, MODE, TX_LINE_CLOCK, TX_POS_RAIL, TX_NEG_RAIL, REMOTE_LOOP_PIN, LINE_RX_A, LINE_RX_B}),
    .q(pins_s)
  );
  assign {mclk_s, mode_s, tx_line_clock_s, pos_s, neg_s, rloop_s, rxa_s, rxb_s} = pins_s;

  // delayed copies for edge finding
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      mclk_d <= 1'b0;
      tx_line_clock_d <= 1'b0;
      rxa_d <= 1'b0;
      rxb_d <= 1'b0;
    end else begin
      mclk_d <= mclk_s;
      tx_line_clock_d <= tx_line_clock_s;
      rxa_d <= rxa_s;
      rxb_d <= rxb_s;
    end
  end

  logic mclk_rise, mclk_fall, tx_line_clock_rise, tx_line_clock_fall, mark_a, mark_b, mark_any;
  assign mclk_rise = mclk_s & ~mclk_d;
  assign mclk_fall = ~mclk_s & mclk_d;
  assign tx_line_clock_rise = tx_line_clock_s & ~tx_line_clock_d;
  assign tx_line_clock_fall = ~tx_line_clock_s & tx_line_clock_d;
  assign mark_a = rxa_s & ~rxa_d;
  assign mark_b = rxb_s & ~rxb_d;
  assign mark_any = mark_a | mark_b;

  // ----------------------------------------------------------------
  // control register and mode selection
  // ----------------------------------------------------------------
  logic [`CTRL_W-1:0] ctrl_r;   // edge select and loopback
  logic [`INT_W-1:0] int_stat_r, int_mask_r;
  logic host, loop_act, edge_sel;
  logic wr_ok;                  // write accepted

  assign host = mode_s;
  assign wr_ok = REG_WR & host;
  assign loop_act = host ? ctrl_r[`CTRL_RLOOP_BIT] : rloop_s;
  assign edge_sel = host ? ctrl_r[`CTRL_EDGE_BIT] : 1'b0;

  // control writes
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      ctrl_r <= `CTRL_RESET;
    end else if (wr_ok && REG_ADDR == `REG_CTRL) begin
      ctrl_r <= REG_WDATA[`CTRL_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // master clock period measurement
  // ----------------------------------------------------------------
  logic [`PER_W-1:0] mcnt_r, period_r, half;

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      mcnt_r <= '0;
      period_r <= `PERIOD_INIT;
    end else if (mclk_rise) begin
      mcnt_r <= '0;
      period_r <= (mcnt_r == `PERIOD_MAX) ? `PERIOD_MAX : mcnt_r + 8'h01;
    end else if (mcnt_r != `PERIOD_MAX) begin
      mcnt_r <= mcnt_r + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // transmit clock stall watch and driver state
  // ----------------------------------------------------------------
  logic [`IDLE_W-1:0] idle_cnt_r;  // cycles since last clock edge
  logic tx_idle_r;
  logic ev_tx_idle;
  t1e1_line_pkg::tx_state_t state_r, state_nxt;

  assign ev_tx_idle = (idle_cnt_r == 9'(`TX_IDLE_CYCLES - 1)) & ~tx_line_clock_rise & ~tx_line_clock_fall;

  // stall counter, restarted by any edge
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      idle_cnt_r <= '0;
      tx_idle_r <= 1'b1;
    end else if (tx_line_clock_rise || tx_line_clock_fall) begin
      idle_cnt_r <= '0;
      tx_idle_r <= 1'b0;
    end else if (ev_tx_idle) begin
      idle_cnt_r <= idle_cnt_r + 9'h001;
      tx_idle_r <= 1'b1;
    end else if (!tx_idle_r) begin
      idle_cnt_r <= idle_cnt_r + 9'h001;
    end
  end

  always_comb begin
    if (loop_act) begin
      state_nxt = t1e1_line_pkg::TX_LOOP;
    end else if (tx_idle_r) begin
      state_nxt = t1e1_line_pkg::TX_OFF;
    end else begin
      state_nxt = t1e1_line_pkg::TX_SEND;
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      state_r <= t1e1_line_pkg::TX_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // transmit capture, return to zero at clock rise
  // ----------------------------------------------------------------
  logic tx_p_q, tx_n_q;
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      tx_p_q <= 1'b0;
      tx_n_q <= 1'b0;
    end else if (tx_line_clock_fall) begin
      tx_p_q <= pos_s;
      tx_n_q <= neg_s;
    end else if (tx_line_clock_rise) begin
      tx_p_q <= 1'b0;
      tx_n_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // recovered timing: phase counter or master clock
  // ----------------------------------------------------------------
  logic [`PER_W-1:0] phase_r;
  logic los_r, rclk_r;
  logic tick_start, tick_half;
  t1e1_line_pkg::rclk_src_t src;

  assign src = los_r ? t1e1_line_pkg::SRC_MASTER : t1e1_line_pkg::SRC_LINE;

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      phase_r <= '0;
    end else if (mark_any || phase_r >= period_r - 8'h01) begin
      phase_r <= '0;
    end else begin
      phase_r <= phase_r + 8'h01;
    end
  end

  // half point latched at bit start so a new period cannot skip it mid bit
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      half <= `PERIOD_INIT >> 1;
    end else if (phase_r == 8'h00) begin
      half <= {1'b0, period_r[`PER_W-1:1]};
    end
  end

  // bit boundaries from the selected source
  always_comb begin
    case (src)
      t1e1_line_pkg::SRC_MASTER: begin
        tick_start = mclk_rise;
        tick_half = mclk_fall;
      end
      default: begin
        tick_start = (phase_r == 8'h00);
        tick_half = (phase_r == half);
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      rclk_r <= 1'b0;
    end else if (src == t1e1_line_pkg::SRC_MASTER) begin
      rclk_r <= mclk_s;
    end else begin
      rclk_r <= (phase_r < half);
    end
  end

  // ----------------------------------------------------------------
  // receive data recovery
  // ----------------------------------------------------------------
  logic pend_p_r, pend_n_r, bit_p_r, bit_n_r, cur_p, cur_n, upd;
  logic rxp_r, rxn_r;
  assign cur_p = pend_p_r | mark_a;
  assign cur_n = pend_n_r | mark_b;
  assign upd = edge_sel ? tick_start : tick_half;

  // pending marks, cleared at the half point; a mark in that cycle goes into the bit
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      pend_p_r <= 1'b0;
      pend_n_r <= 1'b0;
      bit_p_r <= 1'b0;
      bit_n_r <= 1'b0;
    end else if (tick_half) begin
      pend_p_r <= 1'b0;
      pend_n_r <= 1'b0;
      bit_p_r <= cur_p;
      bit_n_r <= cur_n;
    end else begin
      pend_p_r <= cur_p;
      pend_n_r <= cur_n;
    end
  end

  // rails change only at the update point
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      rxp_r <= 1'b0;
      rxn_r <= 1'b0;
    end else if (upd) begin
      rxp_r <= edge_sel ? bit_p_r : cur_p;
      rxn_r <= edge_sel ? bit_n_r : cur_n;
    end
  end

  // ----------------------------------------------------------------
  // loss of signal detection
  // ----------------------------------------------------------------
  logic [`PER_W-1:0] space_cnt_r;
  logic ev_los_set, ev_los_clr;
  assign ev_los_set = tick_half & ~cur_p & ~cur_n & ~los_r & (space_cnt_r == 8'(`LOS_SPACE_RUN - 8'h01));
  assign ev_los_clr = mark_any & los_r;

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      space_cnt_r <= '0;
      los_r <= 1'b1;
    end else if (mark_any) begin
      space_cnt_r <= '0;
      los_r <= 1'b0;
    end else if (tick_half && !cur_p && !cur_n) begin
      if (space_cnt_r != `LOS_SPACE_RUN) begin
        space_cnt_r <= space_cnt_r + 8'h01;
      end
      if (ev_los_set) begin
        los_r <= 1'b1;
      end
    end else if (tick_half) begin
      space_cnt_r <= '0;
    end
  end

  // ----------------------------------------------------------------
  // line drivers
  // ----------------------------------------------------------------
  // rail requests become line pulses
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      LINE_TX_A <= 1'b0;
      LINE_TX_B <= 1'b0;
      LINE_TX_A_OE_N <= 1'b1;
      LINE_TX_B_OE_N <= 1'b1;
    end else begin
      case (state_r)
        t1e1_line_pkg::TX_SEND: begin
          LINE_TX_A <= tx_p_q;
          LINE_TX_B <= tx_n_q & ~tx_p_q;
          LINE_TX_A_OE_N <= 1'b0;
          LINE_TX_B_OE_N <= 1'b0;
        end
        t1e1_line_pkg::TX_LOOP: begin
          LINE_TX_A <= rxp_r & rclk_r;
          LINE_TX_B <= rxn_r & rclk_r & ~rxp_r;
          LINE_TX_A_OE_N <= 1'b0;
          LINE_TX_B_OE_N <= 1'b0;
        end
        default: begin
          LINE_TX_A <= 1'b0;
          LINE_TX_B <= 1'b0;
          LINE_TX_A_OE_N <= 1'b1;
          LINE_TX_B_OE_N <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // interrupt status, mask and register reads
  // ----------------------------------------------------------------
  logic [`INT_W-1:0] ev_vec, clr_vec;
  assign ev_vec = {ev_tx_idle, ev_los_clr, ev_los_set};
  assign clr_vec = (wr_ok && REG_ADDR == `REG_INT_STAT) ? REG_WDATA[`INT_W-1:0] : `INT_RESET;

  // sticky bits, an event beats its clear
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      int_stat_r <= `INT_RESET;
      int_mask_r <= `INT_RESET;
      IRQ <= 1'b0;
    end else begin
      int_stat_r <= (int_stat_r & ~clr_vec) | ev_vec;
      if (wr_ok && REG_ADDR == `REG_INT_MASK) begin
        int_mask_r <= REG_WDATA[`INT_W-1:0];
      end
      IRQ <= host & |(int_stat_r & int_mask_r);
    end
  end

  logic [`ST_W-1:0] status;
  assign status = {loop_act, host, tx_idle_r, los_r};

  // read data for one cycle only
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      REG_RDATA <= 32'h0000_0000;
    end else if (REG_RD && host) begin
      case (REG_ADDR)
        `REG_CTRL: REG_RDATA <= {30'h0, ctrl_r};
        `REG_STATUS: REG_RDATA <= {28'h0, status};
        `REG_INT_STAT: REG_RDATA <= {29'h0, int_stat_r};
        `REG_INT_MASK: REG_RDATA <= {29'h0, int_mask_r};
        default: REG_RDATA <= 32'h0000_0000;
      endcase
    end else begin
      REG_RDATA <= 32'h0000_0000;
    end
  end

  assign RX_POS_RAIL = rxp_r;
  assign RX_NEG_RAIL = rxn_r;
  assign RX_CLOCK = rclk_r;
  assign SIGNAL_LOST_FLAG = los_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  sequence los_trigger;
    tick_half && !cur_p && !cur_n && !mark_any && space_cnt_r == 8'hAE;
  endsequence
  sequence tx_stalled;
    (tx_idle_r && !loop_act)[*2];
  endsequence

  tx_capture_a: assert property (tx_line_clock_fall |=> tx_p_q == $past(pos_s) && tx_n_q == $past(neg_s))
    else $error("transmit rails not captured at clock fall");
  tx_hiz_a: assert property (tx_stalled |=> LINE_TX_A_OE_N && LINE_TX_B_OE_N)
    else $error("drivers not released on stalled clock");
  period_meas_a: assert property (mclk_rise && mcnt_r < 8'hFE |=> period_r == $past(mcnt_r) + 8'h01)
    else $error("master period not measured");
  los_clock_a: assert property (los_r |=> RX_CLOCK == $past(mclk_s))
    else $error("recovered clock not master clock in loss");
  mark_align_a: assert property (mark_any |=> phase_r == 8'h00)
    else $error("mark did not realign phase");
  tx_pulse_a: assert property (state_r == t1e1_line_pkg::TX_SEND && tx_p_q |=> LINE_TX_A && !LINE_TX_A_OE_N)
    else $error("positive request gave no pulse");
  host_write_a: assert property (host && REG_WR && REG_ADDR == 8'h00 |=> ctrl_r == $past(REG_WDATA[1:0]))
    else $error("host write to control lost");
  hw_disable_a: assert property (!host && !$past(host) |=> REG_RDATA == 32'h0 && !IRQ)
    else $error("register port active in hardware mode");
  rx_mark_a: assert property (!edge_sel && tick_half && cur_p |=> RX_POS_RAIL)
    else $error("received positive pulse not shown");
  nrz_hold_a: assert property (!upd |=> $stable(RX_POS_RAIL) && $stable(RX_NEG_RAIL))
    else $error("receive rail changed mid bit");
  rise_valid_a: assert property (!host && $rose(RX_CLOCK) |-> $stable(RX_POS_RAIL) && $stable(RX_NEG_RAIL))
    else $error("rails changed at clock rise");
  fall_valid_a: assert property (host && edge_sel && $fell(RX_CLOCK) |-> $stable(RX_POS_RAIL))
    else $error("rails changed at selected falling edge");
  los_set_a: assert property (los_trigger |=> SIGNAL_LOST_FLAG)
    else $error("loss not raised after space run");
  los_clear_a: assert property (mark_any |=> !SIGNAL_LOST_FLAG ##1 space_cnt_r <= 8'h01)
    else $error("mark did not clear loss");
endmodule : t1e1_line_if

// ==== sim/framer_model.sv ====
// framer model: makes the transmit clock and the two transmit rails
// assumes the bench raises run to start frames; clock grounded otherwise
`timescale 1ns/1ps
module framer_model (
  input wire logic run,  // clock runs while high
  output logic tx_line_clock,     // transmit clock, 125 ns
  output logic pos,      // positive rail request
  output logic neg       // negative rail request
);
  // ----------------------------------------------------------------
  // clock and rails
  // ----------------------------------------------------------------
  initial begin
    tx_line_clock = 1'b0;
    pos = 1'b0;
    neg = 1'b0;
    forever begin
      #1.3;
      if (run) begin
        tx_line_clock = 1'b1;
        // rails move only after the rise
        #5 pos = $urandom;
        neg = $urandom;
        #57.5 tx_line_clock = 1'b0;
        #61.2;
      end else begin
        // grounded clock; the positive rail wanders so nothing stale is read
        pos = ~pos;
        #3.7;
      end
    end
  end
endmodule : framer_model

// ==== sim/t1e1_dual_rail_line_interface_bench.sv ====
// bench for the line interface: framer model, line stimulus, register port
// assumes a 200 MHz clock and a 1.544 MHz master clock
`timescale 1ns/1ps
`include "t1e1_line_map.svh"
module t1e1_dual_rail_line_interface_bench;
  logic REF_CLK = 1'b0, NRST = 1'b0, MCLK = 1'b0, MODE = 1'b1, REMOTE_LOOP_PIN = 1'b0;
  logic LINE_RX_A = 1'b0, LINE_RX_B = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0, run = 1'b0;
  logic [7:0] REG_ADDR = 8'h00;
  logic [31:0] REG_WDATA = 32'h0, d;
  logic tx_line_clock, pos, neg, tx_a, tx_a_oe_n, tx_b, tx_b_oe_n, rx_p, rx_n, rx_clk, signal_lost_flag, irq;
  logic [31:0] rdata;
  logic [1:0] tx_q[$];  // rails seen at each transmit clock fall
  logic [1:0] e;
  bit tx_chk = 0;
  int n_mismatch = 0, total_checks = 0, n, sym, prev;
  // ----------------------------------------------------------------
  // clocks
  // ----------------------------------------------------------------
  always #2.5 REF_CLK = ~REF_CLK;
  always #324 MCLK = ~MCLK;
  framer_model framer_u (.run(run), .tx_line_clock(tx_line_clock), .pos(pos), .neg(neg));
  t1e1_line_if dut_u (.REF_CLK(REF_CLK), .NRST(NRST), .MCLK(MCLK), .MODE(MODE),
    .TX_LINE_CLOCK(tx_line_clock), .TX_POS_RAIL(pos), .TX_NEG_RAIL(neg),
    .REMOTE_LOOP_PIN(REMOTE_LOOP_PIN), .LINE_RX_A(LINE_RX_A), .LINE_RX_B(LINE_RX_B),
    .LINE_TX_A(tx_a), .LINE_TX_A_OE_N(tx_a_oe_n), .LINE_TX_B(tx_b), .LINE_TX_B_OE_N(tx_b_oe_n),
    .RX_POS_RAIL(rx_p), .RX_NEG_RAIL(rx_n), .RX_CLOCK(rx_clk), .SIGNAL_LOST_FLAG(signal_lost_flag),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(rdata), .IRQ(irq));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    REG_ADDR <= a;
    REG_WDATA <= v;
    REG_WR <= 1'b1;
    @(posedge REF_CLK) REG_WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge REF_CLK) REG_RD <= 1'b0;
    #1 d = rdata;
    @(posedge REF_CLK);
  endtask : rd
  task automatic cyc(input int k);
    repeat (k) @(posedge REF_CLK);
  endtask : cyc
  // ----------------------------------------------------------------
  // transmit model: one line pulse per captured rail, only the positive pulse when both rails are set
  // ----------------------------------------------------------------
  always @(negedge tx_line_clock) if (tx_chk) tx_q.push_back({pos, neg});
  always @(posedge tx_line_clock) begin
    if (tx_chk && tx_q.size() > 0) begin
      e = tx_q.pop_front();
      check("tx_a", tx_a, e[1]);
      check("tx_b", tx_b, e[0] & ~e[1]);
      check("tx_oe_n", tx_a_oe_n, 1'b0);
    end
  end
  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial begin
    #300000;
    n_mismatch++;
    results();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h54D3A864));
    cyc(5);
    NRST <= 1'b1;
    cyc(1);
    check("los_rst", signal_lost_flag, 1'b1);
    check("oe_rst", tx_a_oe_n, 1'b1);
    cyc(3);
    wr(`REG_CTRL, 32'h1);
    rd(`REG_CTRL);
    check("ctrl", d, 32'h1);
    rd(8'h10);
    check("unmapped", d, 32'h0);
    rd(`REG_STATUS);
    check("host_bit", d[`ST_HOST_BIT], 1'b1);
    wr(`REG_CTRL, 32'h0);
    run <= 1'b1;
    tx_chk = 1;
    cyc(2000);
    tx_chk = 0;
    tx_q.delete();
    run <= 1'b0;
    cyc(300);
    check("oe_a_idle", tx_a_oe_n, 1'b1);
    check("oe_b_idle", tx_b_oe_n, 1'b1);
    rd(`REG_INT_STAT);
    check("stall_ev", d[`INT_TX_IDLE_BIT], 1'b1);
    wr(`REG_INT_MASK, 32'h4);
    cyc(3);
    check("irq_on", irq, 1'b1);
    wr(`REG_INT_STAT, 32'h7);
    cyc(3);
    check("irq_off", irq, 1'b0);
    // hardware mode: port refused, pins rule
    MODE <= 1'b0;
    cyc(3);
    rd(`REG_STATUS);
    check("hw_read", d, 32'h0);
    REMOTE_LOOP_PIN <= 1'b1;
    cyc(10);
    check("loop_oe", tx_a_oe_n, 1'b0);
    REMOTE_LOOP_PIN <= 1'b0;
    // random marks, rails checked before the half point (previous symbol) and after it in the same bit
    prev = 0;
    for (int i = 0; i < 12; i++) begin
      sym = (i == 0 || i == 11) ? 1 : $urandom % 3;
      LINE_RX_A <= (sym == 1);
      LINE_RX_B <= (sym == 2);
      cyc(20);
      LINE_RX_A <= 1'b0;
      LINE_RX_B <= 1'b0;
      cyc(20);
      check("rx_p_hold", rx_p, prev == 1);
      check("rx_n_hold", rx_n, prev == 2);
      cyc(60);
      check("rx_p", rx_p, sym == 1);
      check("rx_n", rx_n, sym == 2);
      check("los_clr", signal_lost_flag, 1'b0);
      prev = sym;
      cyc(30);
    end
    // host mode, edge select 1: rails move at bit start, one bit later
    MODE <= 1'b1;
    cyc(3);
    wr(`REG_CTRL, 32'h1);
    LINE_RX_B <= 1'b1;
    cyc(20);
    LINE_RX_B <= 1'b0;
    cyc(180);
    check("rx_n_edge", rx_n, 1'b1);
    check("rx_p_edge", rx_p, 1'b0);
    wr(`REG_CTRL, 32'h0);
    MODE <= 1'b0;
    // flag after the run of spaces
    n = 0;
    while (signal_lost_flag !== 1'b1 && n < 24000) begin
      cyc(1);
      n++;
    end
    check("los_time", n >= 22300 && n <= 23100, 1'b1);
    // recovered clock from master during loss
    n = 0;
    prev = rx_clk;
    repeat (1300) begin
      @(posedge REF_CLK);
      #1;
      if (rx_clk && !prev) n++;
      prev = rx_clk;
    end
    check("rclk_master", n >= 8 && n <= 11, 1'b1);
    results();
  end
endmodule : t1e1_dual_rail_line_interface_bench
